// ### rtl/pdc_dma.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_dma
    import pdc_pkg::*;
(
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_SYS_RST,
    input  wire logic                  I_CE,
    // software control and status
    input  wire logic [NUM_CH-1:0]     I_CH_EN,
    input  wire logic                  I_DESC_WR,
    input  wire logic [CH_W-1:0]       I_DESC_CH,
    input  wire logic                  I_DESC_SEL,
    input  wire pdc_desc_t             I_DESC,
    input  wire logic [NUM_CH-1:0]     I_IRQ_MASK,
    output logic [NUM_CH-1:0]          O_NEED_BUF,
    output logic [NUM_CH-1:0]          O_ACTIVE_DESC,
    output logic                       O_IRQ,
    // peripheral request lines, one per channel
    input  wire logic [NUM_CH-1:0]     I_PER_REQ,
    input  wire logic [DATA_W-1:0]     I_RX_DATA,
    output logic [NUM_CH-1:0]          O_PER_ACK,
    output logic [DATA_W-1:0]          O_TX_DATA,
    // system bus master
    output logic                       O_BUS_REQ,
    input  wire logic                  I_BUS_GNT,
    output pdc_beat_t                  O_BUS_BEAT,
    output logic                       O_BUS_VALID,
    input  wire logic                  I_BUS_READY,
    input  wire logic [DATA_W-1:0]     I_BUS_RDATA
);

    // ------------------------------------------------------------
    // channel classification
    // ------------------------------------------------------------
    // channel map
    function automatic logic is_rx(input logic [CH_W-1:0] ch);
        return (ch == CH_CARD_RX) || (ch == CH_USB_RX) ||
               (ch >= CH_AUD_RX0 && ch < CH_AUD_RX0 + CH_W'(AUD_PAIRS));
    endfunction : is_rx

    function automatic logic [2:0] beats_of(input pdc_size_t sz);
        return (sz == PDC_SZ_QUAD) ? BEATS_QUAD : BEATS_SINGLE;
    endfunction : beats_of

    function automatic logic [LEN_W-1:0] bytes_of(input pdc_size_t sz);
        case (sz)
            PDC_SZ_BYTE: return 16'h0001;
            PDC_SZ_WORD: return 16'h0004;
            default:     return 16'h0004;
        endcase
    endfunction : bytes_of

    // ------------------------------------------------------------
    // descriptor storage
    // ------------------------------------------------------------
    pdc_desc_t           desc   [NUM_CH][NUM_DESC];
    logic [LEN_W-1:0]    remain [NUM_CH][NUM_DESC];
    logic [ADDR_W-1:0]   cur    [NUM_CH][NUM_DESC];
    logic [NUM_CH-1:0]   dvalid [NUM_DESC];
    logic [NUM_CH-1:0]   act;
    logic [NUM_CH-1:0]   need_buf;
    logic                irq;

    pdc_state_t          state;
    logic [CH_W-1:0]     gch;
    logic [2:0]          beat_left;
    logic                exhaust;
    pdc_beat_t           beat;
    logic                bus_valid;
    logic                bus_req;
    logic [NUM_CH-1:0]   per_ack;
    logic [DATA_W-1:0]   tx_data;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    wire  [NUM_CH-1:0] cand;
    logic [CH_W-1:0]   win;
    logic              any;

    // a channel is eligible only while its active descriptor holds
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_cand
            assign cand[g] = I_CH_EN[g] && I_PER_REQ[g] &&
                             dvalid[act[g]][g];
        end
    endgenerate

    always_comb begin
        win = '0;
        any = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (cand[i]) begin
                win = CH_W'(i);
                any = 1'b1;
            end
        end
    end

    wire        g_act  = act[gch];
    wire        g_rx   = is_rx(gch);
    pdc_desc_t  g_desc;
    assign g_desc = desc[gch][g_act];
    wire [LEN_W-1:0] step  = bytes_of(g_desc.size);
    wire [LEN_W-1:0] g_rem = remain[gch][g_act];
    wire             last_beat = (beat_left == 3'h1) || (g_rem <= step);
    wire             beat_done = bus_valid && I_BUS_READY;

    // rx fifo between peripheral capture and memory write
    pdc_word_t fifo_in;
    pdc_word_t fifo_out;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    wire       fifo_push = (state == PDC_REQ) && g_rx && I_BUS_GNT;
    wire       fifo_pop  = beat_done && g_rx;
    assign fifo_in.data = I_RX_DATA;
    assign fifo_in.ch   = gch;

    pdc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk       (I_REF_CLK),
        .i_rst       (I_SYS_RST),
        .i_ce        (I_CE),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out)
    );

    // ------------------------------------------------------------
    // engine
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            state     <= PDC_IDLE;
            gch       <= '0;
            beat_left <= '0;
            bus_req   <= 1'b0;
            bus_valid <= 1'b0;
            beat      <= '0;
            per_ack   <= '0;
            tx_data   <= '0;
            exhaust   <= 1'b0;
        end else if (I_CE) begin
            per_ack <= '0;
            exhaust <= 1'b0;
            case (state)
                PDC_IDLE: begin
                    // internal winner goes to the system arbiter
                    if (any) begin
                        gch     <= win;
                        bus_req <= 1'b1;
                        state   <= PDC_REQ;
                    end
                end
                PDC_REQ: begin
                    // rx stalls while the fifo is full
                    if (I_BUS_GNT && (!g_rx || fifo_in_ready)) begin
                        // quadword is a four beat burst
                        beat_left   <= beats_of(g_desc.size);
                        // master access on the system bus
                        // one side is always the peripheral
                        beat.addr   <= cur[gch][g_act];
                        beat.write  <= g_rx;
                        beat.size   <= g_desc.size;
                        beat.ch     <= gch;
                        beat.data   <= I_RX_DATA;
                        bus_valid   <= 1'b1;
                        state       <= PDC_XFER;
                    end
                end
                PDC_XFER: begin
                    if (beat_done) begin
                        if (!g_rx) begin
                            tx_data <= I_BUS_RDATA;
                        end
                        per_ack[gch] <= 1'b1;
                        beat.addr    <= beat.addr + ADDR_W'(step);
                        beat_left    <= beat_left - 3'h1;
                        if (last_beat) begin
                            bus_valid <= 1'b0;
                            bus_req   <= 1'b0;
                            exhaust   <= (g_rem <= step);
                            state     <= PDC_DONE;
                        end
                    end
                end
                PDC_DONE: begin
                    state <= PDC_IDLE;
                end
                default: begin
                    state <= PDC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // descriptor bookkeeping
    // ------------------------------------------------------------
    wire [LEN_W-1:0] next_rem = (g_rem > step) ? g_rem - step : LEN_ZERO;

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            act       <= '0;
            dvalid[0] <= '0;
            dvalid[1] <= '0;
            need_buf  <= '0;
            irq       <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                for (int d = 0; d < NUM_DESC; d++) begin
                    desc[c][d]   <= '0;
                    remain[c][d] <= '0;
                    cur[c][d]    <= '0;
                end
            end
        end else if (I_CE) begin
            // software loads a descriptor and clears need flag
            if (I_DESC_WR) begin
                desc[I_DESC_CH][I_DESC_SEL]   <= I_DESC;
                remain[I_DESC_CH][I_DESC_SEL] <= I_DESC.len;
                cur[I_DESC_CH][I_DESC_SEL]    <= I_DESC.base;
                dvalid[I_DESC_SEL][I_DESC_CH] <= (I_DESC.len != LEN_ZERO);
                need_buf[I_DESC_CH]           <= 1'b0;
            end
            if (state == PDC_XFER && beat_done) begin
                remain[gch][g_act] <= next_rem;
                cur[gch][g_act]    <= cur[gch][g_act] + ADDR_W'(step);
            end
            // exhausted: flip descriptor, alternating between the two
            if (exhaust) begin
                dvalid[act[gch]][gch] <= 1'b0;
                act[gch]              <= ~act[gch];
                // set wins over a same-cycle software clear
                need_buf[gch]         <= 1'b1;
            end
            irq <= |(need_buf & I_IRQ_MASK);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // single masked interrupt
    assign O_IRQ         = irq;
    assign O_NEED_BUF    = need_buf;
    assign O_ACTIVE_DESC = act;
    assign O_PER_ACK     = per_ack;
    assign O_TX_DATA     = tx_data;
    assign O_BUS_REQ     = bus_req;
    assign O_BUS_VALID   = bus_valid;
    assign O_BUS_BEAT    = beat;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_grant_held: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (state == PDC_XFER && I_CE) |=> (gch == $past(gch)))
        else $error("granted channel changed mid-burst");

    chk_req_follows_win: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (state == PDC_IDLE && any && I_CE) |=> (bus_req && gch == $past(win)))
        else $error("bus request not raised for winner");

    chk_one_ack_only: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) $onehot0(per_ack))
        else $error("more than one channel acknowledged");

    chk_flip_on_exhaust: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (exhaust && I_CE) |=> (act[gch] != $past(act[gch])))
        else $error("descriptor did not switch");

    chk_need_set: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (exhaust && I_CE) |=> need_buf[gch])
        else $error("need flag not set");

    chk_irq_mask: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        I_CE ##1 (irq != |($past(need_buf) & $past(I_IRQ_MASK)))
        |-> !$past(I_CE))
        else $error("interrupt disagrees with masked flags");

    chk_rx_is_write: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        bus_valid |-> (beat.write == is_rx(beat.ch)))
        else $error("direction wrong for channel");

    chk_quad_beats: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (state == PDC_REQ && I_BUS_GNT && I_CE && g_desc.size == PDC_SZ_QUAD
         && (!g_rx || fifo_in_ready)) |=> (beat_left == BEATS_QUAD))
        else $error("quadword burst length wrong");

    // the captured rx word is what goes out on the bus
    chk_rx_fifo_data: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (bus_valid && beat.write && fifo_out_valid) |->
        (beat.data == fifo_out.data && beat.ch == fifo_out.ch))
        else $error("rx beat differs from captured word");

    chk_ack_per_beat: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (state == PDC_XFER && beat_done && I_CE) |=> per_ack[gch])
        else $error("accepted beat not acknowledged");

    chk_valid_with_req: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) bus_valid |-> bus_req)
        else $error("beat offered without bus request");

    cov_quad: cover property (@(posedge I_REF_CLK)
        bus_valid && beat.size == PDC_SZ_QUAD);
    cov_switch: cover property (@(posedge I_REF_CLK) exhaust);
    cov_rx: cover property (@(posedge I_REF_CLK) fifo_pop);
    cov_irq: cover property (@(posedge I_REF_CLK) $rose(irq));

endmodule : pdc_dma
`default_nettype wire

// ### rtl/pdc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = i_in_valid && o_in_ready && i_ce;
    wire              pop  = o_out_valid && i_out_ready && i_ce;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // occupancy must never pass the depth, whatever push and pop do
    chk_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (i_rst)
        count <= (AW+1)'(DEPTH))
        else $error("fifo accepts while full");

endmodule : pdc_fifo
`default_nettype wire

// ### rtl/pdc_pkg.sv
package pdc_pkg;

    // ------------------------------------------------------------
    // channel map
    // ------------------------------------------------------------
    localparam int NUM_CH      = 10;
    localparam int CH_W        = 4;
    localparam int NUM_PERIPH  = 3;
    localparam int NUM_DESC    = 2;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 32;
    localparam int LEN_W       = 16;
    localparam int FIFO_DEPTH  = 8;

    // channel index: 0 card tx, 1 card rx, 2 usb tx, 3 usb rx,
    // 4..6 audio tx, 7..9 audio rx
    localparam logic [CH_W-1:0] CH_CARD_TX   = 4'h0;
    localparam logic [CH_W-1:0] CH_CARD_RX   = 4'h1;
    localparam logic [CH_W-1:0] CH_USB_TX    = 4'h2;
    localparam logic [CH_W-1:0] CH_USB_RX    = 4'h3;
    localparam logic [CH_W-1:0] CH_AUD_TX0   = 4'h4;
    localparam logic [CH_W-1:0] CH_AUD_RX0   = 4'h7;
    localparam int              AUD_PAIRS    = 3;

    // transfer size encodings
    typedef enum logic [1:0] {
        PDC_SZ_BYTE = 2'h0,
        PDC_SZ_WORD = 2'h1,
        PDC_SZ_QUAD = 2'h2
    } pdc_size_t;

    localparam logic [2:0] BEATS_SINGLE = 3'h1;
    localparam logic [2:0] BEATS_QUAD   = 3'h4;

    // engine states, gray along idle-req-xfer-done
    typedef enum logic [1:0] {
        PDC_IDLE = 2'b00,
        PDC_REQ  = 2'b01,
        PDC_XFER = 2'b11,
        PDC_DONE = 2'b10
    } pdc_state_t;

    // buffer descriptor written by software
    typedef struct packed {
        logic [ADDR_W-1:0] base;
        logic [LEN_W-1:0]  len;
        pdc_size_t         size;
    } pdc_desc_t;

    // one memory-side beat
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              write;
        pdc_size_t         size;
        logic [CH_W-1:0]   ch;
    } pdc_beat_t;

    // receive data entry through the fifo
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CH_W-1:0]   ch;
    } pdc_word_t;

    localparam int WORD_W = DATA_W + CH_W;

    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;

endpackage : pdc_pkg

// ### verification/pdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_mem_model
    import pdc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_slow,
    input  wire logic              i_bus_req,
    output logic                   o_bus_gnt,
    input  wire pdc_beat_t         i_beat,
    input  wire logic              i_bus_valid,
    output logic                   o_bus_ready,
    output logic      [DATA_W-1:0] o_rdata,
    output pdc_beat_t              o_last,
    output logic      [15:0]       o_beats
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic       take;
    logic       next_ready;
    logic [1:0] stall;

    assign take       = i_bus_valid && o_bus_ready;
    // grant follows request
    // slow mode accepts one beat in four to stress the held request
    assign next_ready = i_bus_valid && o_bus_gnt && !take
                        && (!i_slow || stall == 2'h3);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bus_gnt   <= 1'b0;
            o_bus_ready <= 1'b0;
            stall       <= 2'h0;
            o_rdata     <= 32'h0;
            o_last      <= '0;
            o_beats     <= 16'h0;
        end else begin
            o_bus_gnt   <= i_bus_req;
            o_bus_ready <= next_ready;
            stall       <= stall + 2'h1;
            // outside a beat the read data toggles, never holds
            o_rdata     <= next_ready ? ~i_beat.addr : ~o_rdata;
            if (take) begin
                o_last  <= i_beat;
                o_beats <= o_beats + 16'h1;
            end
        end
    end
endmodule : pdc_mem_model
`default_nettype wire

// ### verification/test_peripheral_dma_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_dma_controller
    import pdc_pkg::*;
;
    typedef struct packed {
        logic [3:0]  ch;
        logic [31:0] base;
        logic [15:0] len;
        pdc_size_t   sz;
        logic [7:0]  nb;
        logic        wr;
        logic        slow;
    } pdc_row_t;

    logic clk, rst, ce, desc_wr, desc_sel, irq, bus_req, bus_gnt;
    logic bus_valid, bus_ready, slow;
    logic [3:0] desc_ch;
    pdc_desc_t desc;
    logic [9:0] ch_en, irq_mask, need_buf, active_desc, per_req, per_ack;
    logic [31:0] rx_data, tx_data, bus_rdata;
    logic [15:0] beats;
    pdc_beat_t beat, last;
    pdc_row_t rows [10];
    pdc_row_t r;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] b0;

    pdc_dma u_pdc_dma (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CE(ce),
        .I_CH_EN(ch_en), .I_DESC_WR(desc_wr), .I_DESC_CH(desc_ch),
        .I_DESC_SEL(desc_sel), .I_DESC(desc), .I_IRQ_MASK(irq_mask),
        .O_NEED_BUF(need_buf), .O_ACTIVE_DESC(active_desc), .O_IRQ(irq),
        .I_PER_REQ(per_req), .I_RX_DATA(rx_data), .O_PER_ACK(per_ack),
        .O_TX_DATA(tx_data), .O_BUS_REQ(bus_req), .I_BUS_GNT(bus_gnt),
        .O_BUS_BEAT(beat), .O_BUS_VALID(bus_valid),
        .I_BUS_READY(bus_ready), .I_BUS_RDATA(bus_rdata));

    pdc_mem_model u_pdc_mem_model (.i_clk(clk), .i_rst(rst), .i_slow(slow),
        .i_bus_req(bus_req), .o_bus_gnt(bus_gnt), .i_beat(beat),
        .i_bus_valid(bus_valid), .o_bus_ready(bus_ready),
        .o_rdata(bus_rdata), .o_last(last), .o_beats(beats));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic load(input logic [3:0] ch, input logic sel,
                        input logic [31:0] base, input logic [15:0] len);
        desc_ch  = ch;
        desc_sel = sel;
        desc     = '{base, len, PDC_SZ_WORD};
        desc_wr  = 1'b1;
        tick(1);
        desc_wr  = 1'b0;
        tick(1);
    endtask : load

    // one buffer, request held until the channel reports it exhausted
    task automatic run(input pdc_row_t q);
        int got;
        int bound;
        logic [31:0] step;
        logic [31:0] exp_d;
        logic act;
        step  = (q.sz == PDC_SZ_BYTE) ? 32'h1 : 32'h4;
        act   = active_desc[q.ch];
        b0    = beats;
        slow  = q.slow;
        got   = 0;
        bound = 0;
        rx_data = 32'hc0de_0a50 + q.ch;
        per_req[q.ch] = 1'b1;
        while (got < q.nb && bound < 400) begin
            tick(1);
            bound++;
            if (per_ack != 10'h0) begin
                check(per_ack, 10'h1 << q.ch);
                exp_d = ~(q.base + step * got);
                if (!q.wr) check(tx_data, exp_d);
                got++;
            end
        end
        while (need_buf[q.ch] !== 1'b1 && bound < 410) begin
            tick(1);
            bound++;
        end
        if (bound >= 410) begin
            num_errors++;
            end_sim();
        end
        per_req[q.ch] = 1'b0;
        tick(2);
        check(beats - b0, q.nb);
        check(active_desc[q.ch], !act);
        check(irq, irq_mask[q.ch]);
        check(last.addr, q.base + q.len - step);
        check(last.write, q.wr);
        check(last.size, q.sz);
        check(last.ch, q.ch);
        if (q.wr) check(last.data, rx_data);
    endtask : run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows[0] = '{4'h0, 32'h10000, 16'h3, PDC_SZ_BYTE, 8'h3, 1'b0, 1'b0};
        rows[1] = '{4'h1, 32'h10100, 16'h8, PDC_SZ_WORD, 8'h2, 1'b1, 1'b1};
        rows[2] = '{4'h2, 32'h10200, 16'h10, PDC_SZ_QUAD, 8'h4, 1'b0, 1'b0};
        rows[3] = '{4'h3, 32'h10300, 16'h2, PDC_SZ_BYTE, 8'h2, 1'b1, 1'b0};
        rows[4] = '{4'h4, 32'h10400, 16'h4, PDC_SZ_WORD, 8'h1, 1'b0, 1'b1};
        rows[5] = '{4'h5, 32'h10500, 16'h8, PDC_SZ_QUAD, 8'h2, 1'b0, 1'b0};
        rows[6] = '{4'h6, 32'h10600, 16'h14, PDC_SZ_QUAD, 8'h5, 1'b0, 1'b1};
        rows[7] = '{4'h7, 32'h10700, 16'hc, PDC_SZ_WORD, 8'h3, 1'b1, 1'b0};
        rows[8] = '{4'h8, 32'h10800, 16'h1, PDC_SZ_BYTE, 8'h1, 1'b1, 1'b0};
        rows[9] = '{4'h9, 32'h10900, 16'hc, PDC_SZ_QUAD, 8'h3, 1'b1, 1'b1};
        rst = 1'b1;
        ce = 1'b1;
        ch_en = 10'h3ff;
        irq_mask = 10'h3ff;
        desc_wr = 1'b0;
        desc_ch = 4'h0;
        desc_sel = 1'b0;
        desc = '0;
        per_req = 10'h0;
        rx_data = 32'h0;
        slow = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        tick(1);
        check({need_buf, active_desc, per_ack}, 30'h0);
        check({irq, bus_req, bus_valid}, 3'h0);
        foreach (rows[i]) begin
            r = rows[i];
            desc_ch = r.ch;
            desc_sel = 1'b0;
            desc = '{r.base, r.len, r.sz};
            desc_wr = 1'b1;
            tick(1);
            desc_wr = 1'b0;
            tick(1);
            run(r);
            load(r.ch, 1'b0, 32'h0, 16'h0);
            check(irq, 1'b0);
        end
        // second buffer taken over without software, first refilled
        load(4'h3, 1'b1, 32'h0000_3000, 16'h0008);
        load(4'h3, 1'b0, 32'h0000_4000, 16'h0008);
        run('{4'h3, 32'h0000_3000, 16'h0008, PDC_SZ_WORD, 8'h02, 1'b1, 1'b0});
        irq_mask[3] = 1'b0;
        load(4'h3, 1'b1, 32'h0, 16'h0);
        run('{4'h3, 32'h0000_4000, 16'h0008, PDC_SZ_WORD, 8'h02, 1'b1, 1'b1});
        // no valid buffer on one channel, another disabled
        irq_mask[3] = 1'b1;
        ch_en[9] = 1'b0;
        load(4'h9, active_desc[9], 32'h0000_5000, 16'h0004);
        per_req = 10'h208;
        b0 = beats;
        tick(20);
        check({bus_req, bus_valid, beats - b0}, 18'h0);
        per_req = 10'h0;
        ch_en[9] = 1'b1;
        tick(2);
        // two channels at once: the lower index is served first
        load(4'h6, 1'b0, 32'h0000_6000, 16'h0002);
        load(4'h6, 1'b1, 32'h0000_6000, 16'h0002);
        load(4'h8, 1'b0, 32'h0000_8000, 16'h0002);
        load(4'h8, 1'b1, 32'h0000_8000, 16'h0002);
        per_req = 10'h140;
        for (int k = 0; k < 100 && per_ack == 10'h0; k++) tick(1);
        check(per_ack, 10'h040);
        per_req = 10'h0;
        tick(10);
        // a frozen engine raises no request, then serves once enabled
        ce = 1'b0;
        per_req = 10'h200;
        tick(10);
        check({bus_req, per_ack}, 11'h0);
        ce = 1'b1;
        for (int k = 0; k < 100 && per_ack == 10'h0; k++) tick(1);
        check(per_ack, 10'h200);
        per_req = 10'h0;
        tick(10);
        // reset after the last transfer clears flags, selection and interrupt
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        check({need_buf, active_desc, irq, bus_req}, 22'h0);
        end_sim();
    end
endmodule : test_peripheral_dma_controller
`default_nettype wire
